//--- design/rif_pkg.sv
package rif_pkg;
	localparam logic [7:0] ADDR_CFG      = 8'h30;
	localparam logic [7:0] ADDR_SRC      = 8'h31;
	localparam logic [7:0] ADDR_THS_ZH   = 8'h36;
	localparam logic [7:0] ADDR_THS_ZL   = 8'h37;
	localparam logic [7:0] ADDR_DURATION = 8'h38;
	localparam logic [7:0] RST_CFG       = 8'h00;
	localparam logic [6:0] RST_THS_ZH    = 7'h00;
	localparam logic [7:0] RST_THS_ZL    = 8'h00;
	localparam logic [6:0] RST_DUR_COUNT = 7'h00;
	localparam logic       RST_WAIT      = 1'b0;
	localparam int         CFG_AND_OR    = 7;
	localparam int         CFG_LATCH     = 6;
	localparam int         CFG_ZH        = 5;
	localparam int         CFG_ZL        = 4;
	localparam int         DUR_WAIT_BIT  = 7;
	localparam int         SRC_ACTIVE_BIT = 6;
	localparam int         DUR_W         = 7;
	localparam int         SAMPLE_W      = 16;
	typedef enum logic { RIF_IDLE, RIF_ACTIVE } rif_state_t;
endpackage

//--- design/rif_filt_if.sv
`timescale 1ns/1ps
interface rif_filt_if;
	import rif_pkg::*;
	logic              sample_stb;
	logic              cond;
	logic [DUR_W-1:0]  dur;
	logic              wait_en;
	logic              irq;
	modport ctrl (output sample_stb, output cond, output dur, output wait_en, input irq);
	modport filt (input sample_stb, input cond, input dur, input wait_en, output irq);
endinterface

//--- design/rif_duration_filter.sv
`timescale 1ns/1ps
module rif_duration_filter (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic ce,
	rif_filt_if.filt  fif
);
	import rif_pkg::*;

	typedef struct packed {
		rif_state_t       state;
		logic [DUR_W-1:0] cnt;
		logic             irq;
	} rif_filt_regs_t;

	rif_filt_regs_t s_q;
	rif_filt_regs_t s_d;
	logic [DUR_W:0] cnt_next;

	assign fif.irq = s_q.irq;

	always_comb begin
		s_d      = s_q;
		cnt_next = {1'b0, s_q.cnt} + {{DUR_W{1'b0}}, 1'b1};
		if (fif.sample_stb) begin
			case (s_q.state)
				RIF_IDLE: begin
					if (fif.cond) begin
						// count qualifying samples; zero or one fires on the first
						if (cnt_next >= {1'b0, fif.dur}) begin
							s_d.state = RIF_ACTIVE;
							s_d.irq   = 1'b1;
							s_d.cnt   = '0;
						end else begin
							s_d.cnt = cnt_next[DUR_W-1:0];
						end
					end else begin
						s_d.cnt = '0;
					end
				end
				RIF_ACTIVE: begin
					if (fif.cond) begin
						s_d.cnt = '0;
					end else if (!fif.wait_en) begin
						s_d.state = RIF_IDLE;
						s_d.irq   = 1'b0;
						s_d.cnt   = '0;
					end else if (cnt_next >= {1'b0, fif.dur}) begin
						s_d.state = RIF_IDLE;
						s_d.irq   = 1'b0;
						s_d.cnt   = '0;
					end else begin
						s_d.cnt = cnt_next[DUR_W-1:0];
					end
				end
				default: begin
					s_d = '{state: RIF_IDLE, cnt: '0, irq: 1'b0};
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_q <= '{state: RIF_IDLE, cnt: '0, irq: 1'b0};
		end else if (ce) begin
			s_q <= s_d;
		end
	end
endmodule

//--- design/rif_rate_int_filter.sv
`timescale 1ns/1ps
module rif_rate_int_filter #(
	parameter int SAMPLE_BITS = rif_pkg::SAMPLE_W
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	input  wire logic                   ce,
	input  wire logic                   sample_stb,
	input  wire logic signed [SAMPLE_BITS-1:0] z_sample,
	input  wire logic [3:0]             xy_events,
	input  wire logic [7:0]             reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic [7:0]                  reg_rdata,
	output logic                        reg_rvalid,
	output logic                        first_interrupt_line
);
	import rif_pkg::*;

	// the threshold is fifteen register bits plus a sign, so a narrower sample cannot compare
	if (SAMPLE_BITS < 16) begin
		$error("rif_rate_int_filter: SAMPLE_BITS must be at least 16");
	end
	// the release enable and the duration count share one register byte
	if (DUR_W != 7) begin
		$error("rif_rate_int_filter: DUR_W must be 7");
	end

	typedef struct packed {
		logic [7:0]       cfg;
		logic [6:0]       ths_zh;
		logic [7:0]       z_threshold_lower_bits;
		logic             wait_en;
		logic [DUR_W-1:0] event_duration_count;
		logic [5:0]       src_flags;
		logic             interrupt_active_flag;
		logic             line;
		logic [7:0]       rdata;
		logic             rvalid;
		logic             stb;
		logic             cond;
		logic [5:0]       ev;
	} rif_top_regs_t;

	rif_top_regs_t s_q;
	rif_top_regs_t s_d;
	rif_filt_if    fif ();

	logic signed [SAMPLE_BITS-1:0] z_ths;
	logic [5:0]                    ev_raw;
	logic [5:0]                    ev_en;
	logic [5:0]                    ev_hit;
	logic                          cond_now;
	logic                          src_read;

	function automatic logic [7:0] read_reg(input logic [7:0] a, input rif_top_regs_t s);
		case (a)
			ADDR_CFG:      read_reg = s.cfg;
			ADDR_SRC:      read_reg = {1'b0, s.interrupt_active_flag, s.src_flags};
			ADDR_THS_ZH:   read_reg = {1'b0, s.ths_zh};
			ADDR_THS_ZL:   read_reg = s.z_threshold_lower_bits;
			ADDR_DURATION: read_reg = {s.wait_en, s.event_duration_count};
			default:       read_reg = 8'h00;
		endcase
	endfunction

	function automatic rif_top_regs_t reset_regs();
		reset_regs                        = '0;
		reset_regs.cfg                    = RST_CFG;
		reset_regs.ths_zh                 = RST_THS_ZH;
		reset_regs.z_threshold_lower_bits = RST_THS_ZL;
		reset_regs.wait_en                = RST_WAIT;
		reset_regs.event_duration_count   = RST_DUR_COUNT;
	endfunction

	// AND with nothing enabled would fire forever, so it needs at least one enable
	function automatic logic combine_events(input logic [5:0] hit, input logic [5:0] en,
		input logic and_mode);
		if (and_mode) begin
			combine_events = (en != 6'h00) && (hit == en);
		end else begin
			combine_events = (hit != 6'h00);
		end
	endfunction

	assign z_ths  = SAMPLE_BITS'({1'b0, s_q.ths_zh, s_q.z_threshold_lower_bits});
	// z high, z low, then the x/y events precomputed by the sample path
	assign ev_raw = {z_sample > z_ths, z_sample < z_ths, xy_events};
	assign ev_en  = s_q.cfg[5:0];
	// each event only counts while its own enable bit is set
	for (genvar i = 0; i < 6; i++) begin
		assign ev_hit[i] = ev_raw[i] & ev_en[i];
	end
	assign cond_now = combine_events(ev_hit, ev_en, s_q.cfg[CFG_AND_OR]);
	assign src_read = reg_rd && (reg_addr == ADDR_SRC);

	assign fif.sample_stb = s_q.stb;
	assign fif.cond       = s_q.cond;
	assign fif.dur        = s_q.event_duration_count;
	assign fif.wait_en    = s_q.wait_en;

	rif_duration_filter u_filt (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.ce      (ce),
		.fif     (fif.filt)
	);

	always_comb begin
		s_d        = s_q;
		s_d.rvalid = reg_rd;
		s_d.stb    = sample_stb;
		if (sample_stb) begin
			s_d.cond = cond_now;
			// z_sample is only valid with its strobe, so the latched-mode source flags use this stored copy
			s_d.ev   = ev_hit;
		end
		if (reg_rd) begin
			s_d.rdata = read_reg(reg_addr, s_q);
		end
		if (reg_wr) begin
			case (reg_addr)
				ADDR_CFG:    s_d.cfg = reg_wdata;
				ADDR_THS_ZH: s_d.ths_zh = reg_wdata[6:0];
				ADDR_THS_ZL: s_d.z_threshold_lower_bits = reg_wdata;
				ADDR_DURATION: begin
					s_d.wait_en              = reg_wdata[DUR_WAIT_BIT];
					s_d.event_duration_count = reg_wdata[DUR_W-1:0];
				end
				default: begin
				end
			endcase
		end
		if (s_q.cfg[CFG_LATCH]) begin
			// read clears first; a still-active request sets again in the same cycle
			if (src_read) begin
				s_d.interrupt_active_flag = 1'b0;
				s_d.line                  = 1'b0;
				s_d.src_flags             = 6'h00;
			end
			if (fif.irq) begin
				s_d.interrupt_active_flag = 1'b1;
				s_d.line                  = 1'b1;
				if (!s_q.interrupt_active_flag || src_read) begin
					s_d.src_flags = s_q.ev;
				end
			end
		end else begin
			s_d.interrupt_active_flag = fif.irq;
			s_d.line                  = fif.irq;
			if (sample_stb) begin
				s_d.src_flags = ev_hit;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_q <= reset_regs();
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign reg_rdata            = s_q.rdata;
	assign reg_rvalid           = s_q.rvalid;
	assign first_interrupt_line = s_q.line;
endmodule

//--- dv/rif_int_asserts.sv
`timescale 1ns/1ps
module rif_int_asserts (
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic       ce,
	input wire logic       sample_stb,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire logic       first_interrupt_line
);
	import rif_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n || !ce);
	// readback is checked only when the read follows the write at once
	sequence wr_rd(a);
		reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
	endsequence
	a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
	a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray");
	a_src_top_zero: assert property (reg_rd && reg_addr == ADDR_SRC |=> !reg_rdata[7])
		else $error("bad source");
	a_zl_readback: assert property (wr_rd(ADDR_THS_ZL) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("bad threshold");
	a_dur_readback: assert property (wr_rd(ADDR_DURATION) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("bad duration");
	a_cfg_readback: assert property (wr_rd(ADDR_CFG) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("bad config");
	a_rise_cause: assert property ($rose(first_interrupt_line) |-> $past(sample_stb, 3))
		else $error("stray rise");
	a_fall_cause: assert property ($fell(first_interrupt_line)
		|-> $past(sample_stb, 3) || $past(reg_rd)) else $error("stray fall");
	c_line_rise: cover property ($rose(first_interrupt_line));
	c_line_fall: cover property ($fell(first_interrupt_line));
	c_src_read: cover property (reg_rd && reg_addr == ADDR_SRC);
endmodule
bind rif_rate_int_filter rif_int_asserts u_chk (.*);

//--- dv/rif_host_model.sv
`timescale 1ns/1ps
module rif_host_model (
	input  wire logic       clk_sys,
	output logic      [7:0] reg_addr = 8'h00,
	output logic      [7:0] reg_wdata = 8'h00,
	output logic            reg_wr = 1'b0,
	output logic            reg_rd = 1'b0,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	// a write is always read back at once; a read of the source clears a latched line unless its request is still active
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [8:0] v);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		if (w) begin
			@(negedge clk_sys);
			reg_wr = 1'b0;
			reg_rd = 1'b1;
		end
		// the answer stands only in the cycle after the read strobe is taken
		@(negedge clk_sys);
		v      = {reg_rvalid, reg_rdata};
		reg_rd = 1'b0;
	endtask
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import rif_pkg::*;
	logic              clk_sys = 1'b0, rst_n = 1'b0, sample_stb = 1'b0, ce = 1'b1;
	logic signed [15:0] z_sample = 16'h0000;
	logic        [3:0] xy_events = 4'h0;
	logic        [7:0] reg_addr, reg_wdata, reg_rdata;
	logic              reg_wr, reg_rd, reg_rvalid, first_interrupt_line;
	logic        [8:0] v;
	logic       [19:0] s;
	int                errors = 0, comparisons = 0;
	// steps: 1AADD write+readback, 2AADD read, 0ZZXE sample z, xy events, expected line
	// 3ZZXE: as a sample, but with the clock enable low, so the sample must be lost
	logic       [19:0] steps [39] = '{
		20'h23000, 20'h23100, 20'h23700, 20'h23800, 20'h23F00,
		20'h13740, 20'h13803, 20'h13020,
		20'h06400, 20'h06400, 20'h00000, 20'h06400, 20'h06400, 20'h06401, 20'h00000,
		20'h13882, 20'h06400, 20'h06401, 20'h00001, 20'h00000,
		20'h13800, 20'h13060, 20'h06401, 20'h00001, 20'h23160, 20'h00000, 20'h23100,
		20'h13010, 20'h0FB01, 20'h06400,
		20'h130B0, 20'h06400, 20'h130A2, 20'h06421, 20'h06400, 20'h13022, 20'h00021, 20'h00000,
		20'h30020
	};
	always #5 clk_sys = ~clk_sys;
	rif_rate_int_filter uut (.*);
	rif_host_model      hm (.*);
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge clk_sys);
		rst_n = 1'b1;
		foreach (steps[i]) begin
			s = steps[i];
			if (s[19:16] == 4'h1 || s[19:16] == 4'h2) begin
				hm.xfer(s[16], s[15:8], s[7:0], v);
				chk(v, {1'b1, s[7:0]});
			end else begin
				@(negedge clk_sys);
				ce = (s[19:16] != 4'h3);
				sample_stb = 1'b1;
				z_sample = {{8{s[15]}}, s[15:8]};
				xy_events = s[7:4];
				@(negedge clk_sys);
				sample_stb = 1'b0;
				ce = 1'b1;
				repeat (4) @(negedge clk_sys);
				chk({8'h00, first_interrupt_line}, {8'h00, s[0]});
			end
		end
		wrap_up();
	end
endmodule
